//--- rtl/dse_pkg.sv
/*
  dse_pkg: shared constants of the dma sync event capture map: register
  offsets, field positions, reset values, fixed channel numbers, variants.
  Assumes an apb slave with 32-bit data and a 12-bit byte address.
*/
// How it works
// - sixty-four channels, numbered 0 to 63, each with its own latch bit.
// - each event source is hard-wired to one channel, never programmable.
// - events latch in the event latch registers even while disabled.
// - per-channel transfer priority comes from a per-channel parameter ram.
// - host-port or pci-to-core interrupt feeds channel 0.
// - first memory interface refresh timer feeds channel 3.
// - second memory interface refresh timer feeds channel 20.
// - pin events 4 to 7 feed channels 4 to 7.
// - channel 21 is reserved and its event input is never asserted.
// - viterbi and turbo events on 28 to 31 exist only in full variant.
// - cell receive feeds channel 32, cell transmit feeds channel 40.
// - base variant never asserts the pci or cell interface events.
// - every channel except reserved channel 21 may also be set by completion chaining.
package dse_pkg;

  localparam int unsigned NUM_CH = 64;
  localparam int unsigned ADDR_W = 12;

  // variants of the device
  typedef enum logic [1:0] {
    DSE_BASE,
    DSE_MID,
    DSE_FULL
  } dse_variant_e;

  // register byte offsets
  localparam logic [11:0] OFS_LATCH_LO = 12'h000;
  localparam logic [11:0] OFS_LATCH_HI = 12'h004;
  localparam logic [11:0] OFS_ENABLE_LO = 12'h008;
  localparam logic [11:0] OFS_ENABLE_HI = 12'h00c;
  localparam logic [11:0] OFS_SET_LO = 12'h010;
  localparam logic [11:0] OFS_SET_HI = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h100;
  localparam logic [3:0] PRIO_PAGE = 4'h1;

  // interrupt status fields
  localparam int unsigned IRQ_DISPATCH_BIT = 0;
  localparam int unsigned IRQ_OVERRUN_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  // reset values
  localparam logic [63:0] LATCH_RST = 64'h0;
  localparam logic [63:0] ENABLE_RST = 64'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // fixed channel numbers
  localparam int unsigned CH_HOST = 0;
  localparam int unsigned CH_TIMER0 = 1;
  localparam int unsigned CH_TIMER1 = 2;
  localparam int unsigned CH_MEM_A = 3;
  localparam int unsigned CH_PIN4 = 4;
  localparam int unsigned CH_GPIO0 = 8;
  localparam int unsigned CH_SER0_TX = 12;
  localparam int unsigned CH_SER0_RX = 13;
  localparam int unsigned CH_SER1_TX = 14;
  localparam int unsigned CH_SER1_RX = 15;
  localparam int unsigned CH_SER2_TX = 17;
  localparam int unsigned CH_SER2_RX = 18;
  localparam int unsigned CH_TIMER2 = 19;
  localparam int unsigned CH_MEM_B = 20;
  localparam int unsigned CH_RESERVED = 21;
  localparam int unsigned CH_VIT_RX = 28;
  localparam int unsigned CH_VIT_TX = 29;
  localparam int unsigned CH_TURBO_RX = 30;
  localparam int unsigned CH_TURBO_TX = 31;
  localparam int unsigned CH_CELL_RX = 32;
  localparam int unsigned CH_CELL_TX = 40;
  localparam int unsigned CH_GPIO8 = 48;

endpackage : dse_pkg

//--- rtl/dse_pin_sync.sv
/*
  dse_pin_sync: brings asynchronous event pins into the pclk domain and
  turns each rising edge into a one-cycle pulse.
  Assumes pins hold each level for at least two pclk periods.
*/
`timescale 1ns/100ps
module dse_pin_sync #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and pulses
  input wire logic [W-1:0] pin,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;
  logic [W-1:0] rise_q;
  logic [W-1:0] rise_d;

  // first stage is read only by the second stage
  always_comb begin
    rise_d = sync_q & ~last_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
      rise_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
      rise_q <= rise_d;
    end
  end

  assign rise = rise_q;

endmodule : dse_pin_sync

//--- rtl/dse_event_capture.sv
/*
  dse_event_capture: maps the fixed synchronization events onto 64 dma
  channels, latches them, gates them by enable and hands the winning
  channel with its priority to the transfer engine. apb register slave.
  Assumes same-clock peripheral events are one-cycle pulses and that
  the transfer engine answers xfer_req_valid with xfer_req_ready.
*/
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
module dse_event_capture
  import dse_pkg::*;
#(
  parameter dse_variant_e VARIANT = DSE_FULL,
  parameter int unsigned PRIO_W = 2,
  parameter int unsigned CHANNELS = NUM_CH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // same-clock peripheral events
  input wire logic host_port_event,
  input wire logic pci_event,
  input wire logic timer0_event,
  input wire logic timer1_event,
  input wire logic timer2_event,
  input wire logic mem_a_refresh_event,
  input wire logic mem_b_refresh_event,
  input wire logic serial0_tx_event,
  input wire logic serial0_rx_event,
  input wire logic serial1_tx_event,
  input wire logic serial1_rx_event,
  input wire logic serial2_tx_event,
  input wire logic serial2_rx_event,
  input wire logic viterbi_rx_event,
  input wire logic viterbi_tx_event,
  input wire logic turbo_rx_event,
  input wire logic turbo_tx_event,
  input wire logic cell_rx_event,
  input wire logic cell_tx_event,
  // asynchronous event pins
  input wire logic [3:0] gpio_lo_pin,
  input wire logic [3:0] pin_event_pin,
  input wire logic [7:0] gpio_hi_pin,
  // completion chaining from the transfer engine
  input wire logic chain_valid,
  input wire logic [5:0] chain_channel,
  // request to the transfer engine
  output logic xfer_req_valid,
  output logic [5:0] xfer_req_channel,
  output logic [PRIO_W-1:0] xfer_req_priority,
  input wire logic xfer_req_ready,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // the event map is fixed to exactly this many channels
  if (CHANNELS != NUM_CH) begin : g_bad_channels
    $error("dse_event_capture: CHANNELS must be 64");
  end
  if (PRIO_W < 1 || PRIO_W > 8) begin : g_bad_prio
    $error("dse_event_capture: PRIO_W must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [15:0] pin_rise;

  dse_pin_sync #(
    .W(16)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({gpio_hi_pin, pin_event_pin, gpio_lo_pin}),
    .rise(pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // fixed event map

  localparam bit HAS_CELL = (VARIANT != DSE_BASE);
  localparam bit HAS_PCI = (VARIANT != DSE_BASE);
  localparam bit HAS_CODEC = (VARIANT == DSE_FULL);

  logic [63:0] hw_event;

  always_comb begin
    // unlisted channels, 16, 21, 22-27, 33-39, 41-47, 56-63, stay zero
    hw_event = '0;
    hw_event[CH_HOST] = host_port_event | (HAS_PCI & pci_event);
    hw_event[CH_TIMER0] = timer0_event;
    hw_event[CH_TIMER1] = timer1_event;
    hw_event[CH_MEM_A] = mem_a_refresh_event;
    hw_event[CH_PIN4 +: 4] = pin_rise[7:4];
    hw_event[CH_GPIO0 +: 4] = pin_rise[3:0];
    hw_event[CH_SER0_TX] = serial0_tx_event;
    hw_event[CH_SER0_RX] = serial0_rx_event;
    hw_event[CH_SER1_TX] = serial1_tx_event;
    hw_event[CH_SER1_RX] = serial1_rx_event;
    hw_event[CH_SER2_TX] = serial2_tx_event;
    hw_event[CH_SER2_RX] = serial2_rx_event;
    hw_event[CH_TIMER2] = timer2_event;
    hw_event[CH_MEM_B] = mem_b_refresh_event;
    hw_event[CH_RESERVED] = 1'b0;
    hw_event[CH_VIT_RX] = HAS_CODEC & viterbi_rx_event;
    hw_event[CH_VIT_TX] = HAS_CODEC & viterbi_tx_event;
    hw_event[CH_TURBO_RX] = HAS_CODEC & turbo_rx_event;
    hw_event[CH_TURBO_TX] = HAS_CODEC & turbo_tx_event;
    hw_event[CH_CELL_RX] = HAS_CELL & cell_rx_event;
    hw_event[CH_CELL_TX] = HAS_CELL & cell_tx_event;
    hw_event[CH_GPIO8 +: 8] = pin_rise[15:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic wr_acc;
  logic setup;

  assign setup = psel & ~penable;
  // writes land only at the edge the master samples pready high
  assign wr_acc = psel & penable & pwrite & pready;

  function automatic logic is_prio(input logic [ADDR_W-1:0] a);
    return a[11:8] == PRIO_PAGE;
  endfunction : is_prio

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return wr_acc && a == ofs;
  endfunction : hit

  function automatic logic [63:0] word_lo(input logic [31:0] d);
    return {32'h0, d};
  endfunction : word_lo

  function automatic logic [63:0] word_hi(input logic [31:0] d);
    return {d, 32'h0};
  endfunction : word_hi

  ////////////////////////////////////////////////////////////////////////
  // priority parameter ram

  logic [PRIO_W-1:0] prio_q [NUM_CH];
  logic [PRIO_W-1:0] prio_d [NUM_CH];

  always_comb begin
    prio_d = prio_q;
    if (wr_acc && is_prio(paddr)) begin
      prio_d[paddr[7:2]] = pwdata[PRIO_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        prio_q[i] <= '0;
      end
    end else begin
      prio_q <= prio_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration: lowest priority value wins, then lowest channel

  logic [63:0] latch_q;
  logic [63:0] enable_q;
  logic [63:0] ready_ch;
  logic found;
  logic [5:0] best_ch;
  logic [PRIO_W-1:0] best_prio;

  assign ready_ch = latch_q & enable_q;

  always_comb begin
    found = 1'b0;
    best_ch = '0;
    best_prio = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ready_ch[i] && (!found || prio_q[i] < best_prio)) begin
        found = 1'b1;
        best_ch = 6'(i);
        best_prio = prio_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event latch, enable, dispatch and interrupt state

  logic [63:0] latch_d;
  logic [63:0] enable_d;
  logic [63:0] set_mask;
  logic [63:0] clr_mask;
  logic [63:0] chain_mask;
  logic valid_q;
  logic valid_d;
  logic [5:0] chan_q;
  logic [5:0] chan_d;
  logic [PRIO_W-1:0] rprio_q;
  logic [PRIO_W-1:0] rprio_d;
  logic load;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] status_d;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] mask_d;
  logic [IRQ_W-1:0] ev_irq;
  logic irq_q;
  logic irq_d;

  // the holding stage refills as soon as it empties
  assign load = found && (!valid_q || xfer_req_ready);

  always_comb begin
    chain_mask = '0;
    if (chain_valid) begin
      chain_mask[chain_channel] = 1'b1;
    end
    set_mask = hw_event | chain_mask;
    if (hit(paddr, OFS_SET_LO)) begin
      set_mask = set_mask | word_lo(pwdata);
    end
    if (hit(paddr, OFS_SET_HI)) begin
      set_mask = set_mask | word_hi(pwdata);
    end
    set_mask[CH_RESERVED] = 1'b0;
    clr_mask = '0;
    if (hit(paddr, OFS_LATCH_LO)) begin
      clr_mask = clr_mask | word_lo(pwdata);
    end
    if (hit(paddr, OFS_LATCH_HI)) begin
      clr_mask = clr_mask | word_hi(pwdata);
    end
    if (load) begin
      clr_mask[best_ch] = 1'b1;
    end
    // a new event in the clearing cycle survives
    latch_d = (latch_q & ~clr_mask) | set_mask;

    enable_d = enable_q;
    if (hit(paddr, OFS_ENABLE_LO)) begin
      enable_d[31:0] = pwdata;
    end
    if (hit(paddr, OFS_ENABLE_HI)) begin
      enable_d[63:32] = pwdata;
    end

    valid_d = valid_q;
    chan_d = chan_q;
    rprio_d = rprio_q;
    if (valid_q && xfer_req_ready) begin
      valid_d = 1'b0;
    end
    if (load) begin
      valid_d = 1'b1;
      chan_d = best_ch;
      rprio_d = best_prio;
    end

    ev_irq = '0;
    ev_irq[IRQ_DISPATCH_BIT] = load;
    ev_irq[IRQ_OVERRUN_BIT] = |(set_mask & latch_q & ~clr_mask);
    status_d = status_q;
    if (hit(paddr, OFS_IRQ_STATUS)) begin
      status_d = status_q & ~pwdata[IRQ_W-1:0];
    end
    status_d = status_d | ev_irq;
    mask_d = mask_q;
    if (hit(paddr, OFS_IRQ_MASK)) begin
      mask_d = pwdata[IRQ_W-1:0];
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= LATCH_RST;
      enable_q <= ENABLE_RST;
      valid_q <= 1'b0;
      chan_q <= '0;
      rprio_q <= '0;
      status_q <= '0;
      mask_q <= IRQ_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      enable_q <= enable_d;
      valid_q <= valid_d;
      chan_q <= chan_d;
      rprio_q <= rprio_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait-free access phase after each setup

  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  always_comb begin
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = '0;
    if (setup) begin
      if (is_prio(paddr)) begin
        prdata_d = 32'(prio_q[paddr[7:2]]);
      end else begin
        unique case (paddr)
          OFS_LATCH_LO: prdata_d = latch_q[31:0];
          OFS_LATCH_HI: prdata_d = latch_q[63:32];
          OFS_ENABLE_LO: prdata_d = enable_q[31:0];
          OFS_ENABLE_HI: prdata_d = enable_q[63:32];
          OFS_SET_LO: prdata_d = '0;
          OFS_SET_HI: prdata_d = '0;
          OFS_IRQ_STATUS: prdata_d = 32'(status_q);
          OFS_IRQ_MASK: prdata_d = 32'(mask_q);
          default: pslverr_d = 1'b1;
        endcase
      end
      if (paddr[1:0] != 2'h0) begin
        pslverr_d = 1'b1;
        prdata_d = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign xfer_req_valid = valid_q;
  assign xfer_req_channel = chan_q;
  assign xfer_req_priority = rprio_q;
  assign irq = irq_q;

endmodule : dse_event_capture

//--- bench/dse_periph_model.sv
/* dse_periph_model: peripherals raising sync events and event pins.
   assumes the bench calls its tasks from one process only. */
`timescale 1ns/100ps
module dse_periph_model (
  // clock
  input wire logic pclk,
  // same-clock events, one-cycle pulses
  output logic [18:0] ev,
  // pins: gpio 0-3, event pins 4-7, gpio 8-15
  output logic [15:0] pins
);
  initial begin
    ev = 19'h0;
    pins = 16'h0;
  end
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 19'h0;
  endtask : pulse
  // four cycles each way: the synchroniser needs two
  task automatic pin_edge(input int k);
    @(posedge pclk);
    pins[k] <= 1'b1;
    repeat (4) @(posedge pclk);
    pins[k] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pin_edge
endmodule : dse_periph_model

//--- bench/dse_event_capture_sva.sv
/* dse_event_capture_chk: port assertions of the event capture block.
   assumes one pclk domain and a master that keeps the apb protocol. */
`timescale 1ns/100ps
module dse_event_capture_chk #(
  parameter int unsigned PRIO_W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // transfer request
  input wire logic xfer_req_valid,
  input wire logic [5:0] xfer_req_channel,
  input wire logic [PRIO_W-1:0] xfer_req_priority,
  input wire logic xfer_req_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  a_misaligned_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned not refused");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'hffc |=> pslverr)
    else $error("unmapped not refused");
  a_req_holds: assert property (
    xfer_req_valid && !xfer_req_ready |=> xfer_req_valid && $stable(xfer_req_channel)
      && $stable(xfer_req_priority))
    else $error("request dropped or changed");
  a_no_reserved_ch: assert property (
    xfer_req_valid |-> xfer_req_channel != 6'h15)
    else $error("reserved channel dispatched");
  a_quiet_release: assert property ($rose(presetn) |-> !xfer_req_valid && !pready)
    else $error("outputs active after reset");
endmodule : dse_event_capture_chk
bind dse_event_capture dse_event_capture_chk #(.PRIO_W(PRIO_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_req_valid(xfer_req_valid),
  .xfer_req_channel(xfer_req_channel), .xfer_req_priority(xfer_req_priority),
  .xfer_req_ready(xfer_req_ready));

//--- bench/tb.sv
/* tb: self-checking bench of dse_event_capture with a peripheral model.
   assumes the apb slave answers in a bounded number of cycles. */
`timescale 1ns/100ps
module tb
  import dse_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic chain_valid, xfer_req_valid, xfer_req_ready, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lo, hi;
  logic [5:0] chain_channel, xfer_req_channel;
  logic [1:0] xfer_req_priority;
  logic [18:0] ev;
  logic [15:0] pins;
  int mismatches, checks_done;
  int evch[19] = '{0, 0, 1, 2, 19, 3, 20, 12, 13, 14, 15, 17, 18, 28, 29, 30, 31, 32, 40};
  always #2.5 pclk = ~pclk;
  dse_event_capture #(.VARIANT(DSE_FULL), .PRIO_W(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_port_event(ev[0]), .pci_event(ev[1]), .timer0_event(ev[2]), .timer1_event(ev[3]),
    .timer2_event(ev[4]), .mem_a_refresh_event(ev[5]), .mem_b_refresh_event(ev[6]),
    .serial0_tx_event(ev[7]), .serial0_rx_event(ev[8]), .serial1_tx_event(ev[9]),
    .serial1_rx_event(ev[10]), .serial2_tx_event(ev[11]), .serial2_rx_event(ev[12]),
    .viterbi_rx_event(ev[13]), .viterbi_tx_event(ev[14]), .turbo_rx_event(ev[15]),
    .turbo_tx_event(ev[16]), .cell_rx_event(ev[17]), .cell_tx_event(ev[18]),
    .gpio_lo_pin(pins[3:0]), .pin_event_pin(pins[7:4]), .gpio_hi_pin(pins[15:8]),
    .chain_valid(chain_valid), .chain_channel(chain_channel),
    .xfer_req_valid(xfer_req_valid), .xfer_req_channel(xfer_req_channel),
    .xfer_req_priority(xfer_req_priority), .xfer_req_ready(xfer_req_ready), .irq(irq));
  dse_periph_model u_per (.pclk(pclk), .ev(ev), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic chain(input logic [5:0] ch);
    @(posedge pclk);
    chain_valid <= 1'b1;
    chain_channel <= ch;
    @(posedge pclk);
    chain_valid <= 1'b0;
  endtask : chain
  // the engine stalls two cycles before it accepts
  task automatic take_req(input logic [5:0] ch, input logic [1:0] pr);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (xfer_req_valid !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      final_report();
    end
    repeat (2) @(posedge pclk);
    chk("req_ch", xfer_req_channel, ch);
    chk("req_prio", xfer_req_priority, pr);
    xfer_req_ready <= 1'b1;
    @(posedge pclk);
    xfer_req_ready <= 1'b0;
  endtask : take_req
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic e;
    rd(OFS_ENABLE_HI, hi);
    rd(OFS_LATCH_LO, lo);
    chk("rst_regs", {hi, lo}, {ENABLE_RST[63:32], LATCH_RST[31:0]});
    rd(OFS_IRQ_MASK, lo);
    chk("rst_mask", lo, {30'h0, IRQ_MASK_RST});
    apb(1'b0, 12'hffc, 32'h0, lo, e);
    chk("unmapped", {e, lo}, {1'b1, 32'h0});
    apb(1'b1, 12'h00a, 32'h1, lo, e);
    chk("misaligned", e, 1'b1);
  endtask : t_reset
  task automatic t_latch();
    logic [63:0] x;
    for (int i = 0; i < 35; i++) begin
      if (i < 19) begin
        u_per.pulse(i);
        x = 64'h1 << evch[i];
      end else begin
        u_per.pin_edge(i - 19);
        x = 64'h1 << ((i < 23) ? i - 11 : (i < 27) ? i - 19 : i + 21);
      end
      rd(OFS_LATCH_LO, lo);
      rd(OFS_LATCH_HI, hi);
      chk("latch", {hi, lo}, x);
      wr(OFS_LATCH_LO, x[31:0]);
      wr(OFS_LATCH_HI, x[63:32]);
    end
    chk("disabled_req", xfer_req_valid, 1'b0);
  endtask : t_latch
  task automatic t_reserved();
    wr(OFS_SET_LO, 32'hffffffff);
    wr(OFS_SET_HI, 32'hffffffff);
    rd(OFS_LATCH_LO, lo);
    rd(OFS_LATCH_HI, hi);
    chk("set_all", {hi, lo}, 64'hffffffffffdfffff);
    wr(OFS_LATCH_LO, 32'hffffffff);
    wr(OFS_LATCH_HI, 32'hffffffff);
    chain(6'h15);
    rd(OFS_LATCH_LO, lo);
    rd(OFS_LATCH_HI, hi);
    chk("chain_21", {hi, lo}, 64'h0);
  endtask : t_reserved
  // pending while disabled, then tie on priority 1 goes to the lower channel
  task automatic t_dispatch();
    wr(OFS_PRIO_BASE + 12'h008, 32'h2);
    wr(OFS_PRIO_BASE + 12'h0a0, 32'h1);
    wr(OFS_PRIO_BASE + 12'h0fc, 32'h1);
    chain(6'h02);
    chain(6'h28);
    chain(6'h3f);
    wr(OFS_ENABLE_HI, 32'h80000100);
    wr(OFS_ENABLE_LO, 32'h00000004);
    take_req(6'h28, 2'h1);
    take_req(6'h3f, 2'h1);
    take_req(6'h02, 2'h2);
    repeat (4) @(posedge pclk);
    chk("idle", {xfer_req_valid, irq}, 2'h0);
    rd(OFS_IRQ_STATUS, lo);
    chk("status", lo, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", irq, 1'b0);
    chain(6'h05);
    chain(6'h05);
    rd(OFS_LATCH_LO, lo);
    chk("pending_5", lo, 32'h20);
    rd(OFS_IRQ_STATUS, lo);
    chk("overrun", lo, 32'h2);
    wr(OFS_IRQ_STATUS, 32'h2);
    wr(OFS_LATCH_LO, 32'h20);
  endtask : t_dispatch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, chain_valid, xfer_req_ready} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    chain_channel = 6'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_latch();
    t_reserved();
    t_dispatch();
    final_report();
  end
endmodule : tb
